/* File: core/scs_top.sv */
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - a closed switch reads as one, an open switch as zero
// - changed switches take effect only after a reset or halt cycle
// - closed run/halt switch holds controller halted; open lets it run
// - three unit switches form unit number, first is least significant
// - closed loop switch makes a failing self-test repeat
// - closed boot switch enables automatic bootstrap
// - closed width switch gives 22-bit addressing, open gives 18-bit, upper undriven
// - burst gap is 4 us when open and 8 us when closed
// - exactly two bus registers at consecutive word addresses from base
// - three base switches pick one of eight octal base addresses
module scs_top
   import scs_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // switch banks, closed contact pulls the input low
   input  wire logic [3:0]  sw1_closed_n_i,
   input  wire logic [7:0]  sw2_closed_n_i,
   // backplane address decode
   input  wire logic [21:0] bus_addr_i,
   output      logic        sel_base_o,
   output      logic        sel_next_o,
   // dma side
   input  wire logic        burst_done_i,
   output      logic        burst_ok_o,
   input  wire logic [21:0] dma_addr_i,
   output      logic [21:0] dma_addr_o,
   output      logic [3:0]  dma_addr_hi_oe_n_o,
   // controller options
   output      logic        ctl_halt_o,
   output      logic [2:0]  unit_num_o,
   output      logic        selftest_loop_o,
   output      logic        auto_boot_o,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output      logic [31:0] dat_o,
   output      logic        ack_o
);
   import scs_pkg::*;

   // ==========================================================
   // switch synchronisers
   logic [3:0]  s1a_ff, s1b_ff;
   logic [7:0]  s2a_ff, s2b_ff;
   logic [3:0]  bank1;
   logic [7:0]  bank2;

   // two stages since the contacts are asynchronous and bounce
   always_ff @(posedge clk_i) begin
      s1a_ff <= ~sw1_closed_n_i;
      s2a_ff <= ~sw2_closed_n_i;
      s1b_ff <= s1a_ff;
      s2b_ff <= s2a_ff;
   end
   assign bank1 = s1b_ff;
   assign bank2 = s2b_ff;

   // ==========================================================
   // software halt register and hold
   logic [31:0] cfg_ff, nxt_cfg;
   logic        hold;
   logic        ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;

   assign hold = rst_i | bank1[SW1_RUN_HALT] | cfg_ff[CFG_SOFT_HALT];

   scs_cfg_if cfg_bus ();

   scs_capture u_cap (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .bank1_i (bank1),
      .bank2_i (bank2),
      .hold_i  (hold),
      .cfg     (cfg_bus.src)
   );

   // ==========================================================
   // base address decode
   function automatic logic [17:0] base_of(input logic [2:0] code);
      case (code)
         3'h0: base_of = BASE_ADDR_0;
         3'h1: base_of = BASE_ADDR_1;
         3'h2: base_of = BASE_ADDR_2;
         3'h3: base_of = BASE_ADDR_3;
         3'h4: base_of = BASE_ADDR_4;
         3'h5: base_of = BASE_ADDR_5;
         3'h6: base_of = BASE_ADDR_6;
         default: base_of = BASE_ADDR_7;
      endcase
   endfunction

   logic [17:0] base;
   logic        io_page;

   // in 18-bit mode address bits above 17 are ignored; in 22-bit the io page sits at the top
   assign base    = base_of(cfg_bus.base_code);
   assign io_page = !cfg_bus.wide_addr || (bus_addr_i[21:18] == 4'hF);
   // never decode while halted or before the switch latch is valid
   assign sel_base_o = cfg_bus.valid && io_page && (bus_addr_i[17:0] == base);
   assign sel_next_o = cfg_bus.valid && io_page
                       && (bus_addr_i[17:0] == 18'(base + REG_STRIDE));

   // ==========================================================
   // dma address width
   // upper four lines stay released in 18-bit mode
   always_comb begin
      dma_addr_o         = dma_addr_i;
      dma_addr_hi_oe_n_o = 4'hF;
      if (cfg_bus.wide_addr) begin
         dma_addr_hi_oe_n_o = 4'h0;
      end else begin
         dma_addr_o[21:18] = 4'h0;
      end
   end

   // ==========================================================
   // burst gap timer
   scs_state_t st_ff, nxt_st;
   logic [GAP_CNT_W-1:0] gap_ff, nxt_gap;

   // gap count loaded at a burst end seen in run state; halt aborts any pending gap
   always_comb begin
      nxt_st  = st_ff;
      nxt_gap = gap_ff;
      case (st_ff)
         SCS_HALTED: begin
            if (cfg_bus.valid) begin
               nxt_st = SCS_RUN;
            end
         end
         SCS_RUN: begin
            if (burst_done_i) begin
               nxt_st  = SCS_GAP;
               nxt_gap = cfg_bus.long_gap ? GAP_CNT_W'(GAP_LONG_CYC - 1) : GAP_CNT_W'(GAP_SHORT_CYC - 1);
            end
         end
         SCS_GAP: begin
            if (gap_ff == '0) begin
               nxt_st = SCS_RUN;
            end else begin
               nxt_gap = gap_ff - 1'b1;
            end
         end
         default: nxt_st = SCS_HALTED;
      endcase
      if (!cfg_bus.valid) begin
         nxt_st  = SCS_HALTED;
         nxt_gap = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff  <= SCS_HALTED;
         gap_ff <= '0;
      end else begin
         st_ff  <= nxt_st;
         gap_ff <= nxt_gap;
      end
   end

   assign burst_ok_o = (st_ff == SCS_RUN);

   // ==========================================================
   // option outputs
   assign ctl_halt_o      = !cfg_bus.valid;
   assign unit_num_o      = cfg_bus.unit_num;
   assign selftest_loop_o = cfg_bus.selftest_loop;
   assign auto_boot_o     = cfg_bus.auto_boot;

   // ==========================================================
   // wishbone slave, one wait cycle then ack
   logic req;
   assign req = cyc_i && stb_i && !ack_ff;

   // unmapped offsets read zero and ignore writes, still acknowledged
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_ack = req;
      nxt_dat = dat_ff;
      if (req) begin
         nxt_dat = 32'h0000_0000;
         case (adr_i)
            OFS_CONFIG: begin
               nxt_dat = cfg_ff;
               if (we_i && sel_i[0]) begin
                  nxt_cfg[CFG_SOFT_HALT] = dat_i[CFG_SOFT_HALT];
               end
            end
            OFS_STATUS: nxt_dat = {20'h0, st_ff == SCS_GAP, cfg_bus.long_gap, cfg_bus.wide_addr,
                                   cfg_bus.base_code, cfg_bus.auto_boot, cfg_bus.selftest_loop,
                                   cfg_bus.unit_num, cfg_bus.valid};
            OFS_DECODE: nxt_dat = {14'h0, base};
            OFS_SWRAW:  nxt_dat = {20'h0, bank2, bank1};
            default:    nxt_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff <= CFG_RESET;
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         cfg_ff <= nxt_cfg;
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;
endmodule // scs_top

/* File: core/scs_pkg.sv */
package scs_pkg;
   // ==========================================================
   // switch bank positions (bank one, bank two)
   localparam int SW1_RUN_HALT    = 0;
   localparam int SW1_UNIT_LSB    = 1;
   localparam int SW2_SELFTEST    = 0;
   localparam int SW2_AUTOBOOT    = 1;
   localparam int SW2_BASE_LSB    = 2;
   localparam int SW2_WIDE_ADDR   = 5;
   localparam int SW2_BURST_GAP   = 6;
   localparam int SW2_SPARE       = 7;

   // ==========================================================
   // base address table, 18-bit octal word addresses
   localparam logic [17:0] BASE_ADDR_0 = 18'o772150;
   localparam logic [17:0] BASE_ADDR_1 = 18'o772154;
   localparam logic [17:0] BASE_ADDR_2 = 18'o760334;
   localparam logic [17:0] BASE_ADDR_3 = 18'o760340;
   localparam logic [17:0] BASE_ADDR_4 = 18'o760344;
   localparam logic [17:0] BASE_ADDR_5 = 18'o760350;
   localparam logic [17:0] BASE_ADDR_6 = 18'o760354;
   localparam logic [17:0] BASE_ADDR_7 = 18'o760360;
   localparam logic [17:0] REG_STRIDE  = 18'h00002;

   // ==========================================================
   // wishbone register map (byte offsets)
   localparam logic [3:0] OFS_CONFIG  = 4'h0;
   localparam logic [3:0] OFS_STATUS  = 4'h4;
   localparam logic [3:0] OFS_DECODE  = 4'h8;
   localparam logic [3:0] OFS_SWRAW   = 4'hC;

   // config register field positions
   localparam int CFG_SOFT_HALT = 0;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // ==========================================================
   // burst gap timing
   localparam int GAP_SHORT_NS = 4000;
   localparam int GAP_LONG_NS  = 8000;
   localparam int CLK_NS       = 4;
   localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_LONG_CYC  = (GAP_LONG_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CNT_W     = 12;

   typedef enum logic [1:0] {SCS_HALTED, SCS_RUN, SCS_GAP} scs_state_t;
endpackage

/* File: core/scs_cfg_if.sv */
`timescale 1ns/1ns
// latched configuration passed from the capture block to the top
interface scs_cfg_if;
   logic        valid;
   logic [2:0]  unit_num;
   logic        selftest_loop;
   logic        auto_boot;
   logic [2:0]  base_code;
   logic        wide_addr;
   logic        long_gap;
   modport src (output valid, unit_num, selftest_loop, auto_boot, base_code, wide_addr, long_gap);
   modport dst (input  valid, unit_num, selftest_loop, auto_boot, base_code, wide_addr, long_gap);
endinterface

/* File: core/scs_capture.sv */
`timescale 1ns/1ns
// ==========================================================
// switch sampling and latch on release of halt/reset
module scs_capture
   import scs_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // synchronised switch banks and hold
   input  wire logic [3:0] bank1_i,
   input  wire logic [7:0] bank2_i,
   input  wire logic       hold_i,
   // latched configuration
   scs_cfg_if.src          cfg
);
   logic       valid_ff, nxt_valid;
   logic [2:0] unit_ff, nxt_unit;
   logic [2:0] base_ff, nxt_base;
   logic [3:0] opt_ff, nxt_opt;

   // latch only at the first cycle out of hold, so a live switch flip is invisible until the next reset or halt
   always_comb begin
      nxt_valid = valid_ff;
      nxt_unit  = unit_ff;
      nxt_base  = base_ff;
      nxt_opt   = opt_ff;
      if (hold_i) begin
         nxt_valid = 1'b0;
      end else if (!valid_ff) begin
         nxt_valid = 1'b1;
         nxt_unit  = bank1_i[SW1_UNIT_LSB +: 3];
         nxt_base  = bank2_i[SW2_BASE_LSB +: 3];
         // spare position deliberately not captured
         nxt_opt   = {bank2_i[SW2_BURST_GAP], bank2_i[SW2_WIDE_ADDR],
                      bank2_i[SW2_AUTOBOOT], bank2_i[SW2_SELFTEST]};
      end
   end

   // state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_ff <= 1'b0;
         unit_ff  <= 3'h0;
         base_ff  <= 3'h0;
         opt_ff   <= 4'h0;
      end else begin
         valid_ff <= nxt_valid;
         unit_ff  <= nxt_unit;
         base_ff  <= nxt_base;
         opt_ff   <= nxt_opt;
      end
   end

   assign cfg.valid         = valid_ff;
   assign cfg.unit_num      = unit_ff;
   assign cfg.base_code     = base_ff;
   assign cfg.selftest_loop = opt_ff[0];
   assign cfg.auto_boot     = opt_ff[1];
   assign cfg.wide_addr     = opt_ff[2];
   assign cfg.long_gap      = opt_ff[3];
endmodule // scs_capture

/* File: tb/scs_top_chk.sv */
`timescale 1ns/1ns
// ==========================================================
// port checks on switch capture, decode, dma lines and gap timing
module scs_top_chk (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // watched inputs
   input wire logic [3:0]  sw1_closed_n_i,
   input wire logic        burst_done_i,
   input wire logic [21:0] dma_addr_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   // watched outputs
   input wire logic        sel_base_o,
   input wire logic        sel_next_o,
   input wire logic        burst_ok_o,
   input wire logic [21:0] dma_addr_o,
   input wire logic [3:0]  dma_addr_hi_oe_n_o,
   input wire logic        ctl_halt_o,
   input wire logic [2:0]  unit_num_o,
   input wire logic        ack_o
);
   logic        gap_on_ff, nxt_gap_on;
   logic [11:0] gap_cnt_ff, nxt_gap_cnt;
   // a halt aborts a gap, so only gaps that run out are measured
   always_comb begin
      nxt_gap_on = gap_on_ff && !burst_ok_o && !ctl_halt_o && !rst_i;
      nxt_gap_cnt = gap_cnt_ff + 12'h001;
      if (burst_done_i && burst_ok_o && !rst_i) begin
         nxt_gap_on = 1'b1;
         nxt_gap_cnt = 12'h001;
      end
   end
   // gap tracker registers
   always_ff @(posedge clk_i) begin
      gap_on_ff <= nxt_gap_on;
      gap_cnt_ff <= nxt_gap_cnt;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_halt_no_sel: assert property (ctl_halt_o |-> !sel_base_o && !sel_next_o)
      else $error("select raised while halted");
   a_halt_switch_acts: assert property ($fell(sw1_closed_n_i[0]) |-> ##[1:4] ctl_halt_o)
      else $error("closed run switch did not halt");
   a_run_frozen: assert property ((!ctl_halt_o) [*3] |-> $stable(unit_num_o))
      else $error("unit number moved while running");
   a_narrow_upper: assert property (&dma_addr_hi_oe_n_o |-> dma_addr_o[21:18] == 4'h0)
      else $error("upper dma lines driven in narrow mode");
   a_wide_pass: assert property (dma_addr_hi_oe_n_o == 4'h0 |-> dma_addr_o == dma_addr_i)
      else $error("wide dma address not passed");
   a_oe_whole: assert property (dma_addr_hi_oe_n_o inside {4'h0, 4'hF})
      else $error("upper enables split");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_gap_hold: assert property (burst_done_i && burst_ok_o |=> !burst_ok_o [*8])
      else $error("gap too short");
   a_gap_length: assert property ($rose(burst_ok_o) && gap_on_ff
      |-> gap_cnt_ff inside {[12'h3E6:12'h3E9], [12'h7CE:12'h7D1]})
      else $error("gap length wrong");
endmodule // scs_top_chk

bind scs_top scs_top_chk scs_top_chk_inst (.clk_i, .rst_i, .sw1_closed_n_i, .burst_done_i, .dma_addr_i, .cyc_i,
   .stb_i, .sel_base_o, .sel_next_o, .burst_ok_o, .dma_addr_o, .dma_addr_hi_oe_n_o, .ctl_halt_o, .unit_num_o, .ack_o);

/* File: tb/scs_host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// host on the backplane: presents a word address, reads the selects
module scs_host_model (
   // clock
   input  wire logic        clk_i,
   // address out, selects back
   output      logic [21:0] bus_addr_o,
   input  wire logic        sel_base_i,
   input  wire logic        sel_next_i
);
   initial bus_addr_o = 22'h000000;
   // lines show the inverse after a probe so a stale match cannot pass
   task automatic probe(input logic [21:0] a, output logic b, output logic n);
      @(posedge clk_i);
      bus_addr_o <= a;
      @(posedge clk_i);
      #1;
      b = sel_base_i;
      n = sel_next_i;
      @(posedge clk_i);
      bus_addr_o <= ~a;
   endtask
endmodule // scs_host_model

/* File: tb/scs_top_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// bench: switch capture, decode table, dma width, gap, registers
module scs_top_tb;
   import scs_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, burst_done_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic sel_base_o, sel_next_o, burst_ok_o, ctl_halt_o, selftest_loop_o, auto_boot_o, ack_o;
   logic [3:0] sw1_closed_n_i = 4'hF, adr_i = 4'h0, dma_addr_hi_oe_n_o;
   logic [7:0] sw2_closed_n_i = 8'hFF;
   logic [21:0] bus_addr_i, dma_addr_o, dma_addr_i = 22'h3FFFFF;
   logic [2:0] unit_num_o;
   logic [31:0] dat_o, rd, dat_i = 32'h0;
   int err_count = 0, total_checks = 0;
   localparam logic [17:0] BASES [8] = '{BASE_ADDR_0, BASE_ADDR_1, BASE_ADDR_2, BASE_ADDR_3,
                                        BASE_ADDR_4, BASE_ADDR_5, BASE_ADDR_6, BASE_ADDR_7};
   scs_top scs_top_inst (.clk_i, .rst_i, .sw1_closed_n_i, .sw2_closed_n_i, .bus_addr_i, .sel_base_o, .sel_next_o,
      .burst_done_i, .burst_ok_o, .dma_addr_i, .dma_addr_o, .dma_addr_hi_oe_n_o, .ctl_halt_o, .unit_num_o,
      .selftest_loop_o, .auto_boot_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o);
   scs_host_model scs_host_model_inst (.clk_i, .bus_addr_o(bus_addr_i), .sel_base_i(sel_base_o), .sel_next_i(sel_next_o));
   always #2 clk_i = ~clk_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // classic cycle: hold until ack is sampled, take data at that edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
      q = dat_o;
      if (n >= 50) err_count++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic probe_chk(input logic [21:0] a, input logic eb, input logic en);
      logic b, n;
      scs_host_model_inst.probe(a, b, n);
      check({b, n}, {eb, en});
   endtask
   // switch values given as closed=1; run switch cycled to make them count
   task automatic apply(input logic [3:0] s1, input logic [7:0] s2);
      logic [2:0] old = unit_num_o;
      @(posedge clk_i);
      sw1_closed_n_i <= {~s1[3:1], 1'b1};
      sw2_closed_n_i <= ~s2;
      repeat (6) @(posedge clk_i);
      check(unit_num_o, old);
      sw1_closed_n_i[0] <= 1'b0;
      repeat (6) @(posedge clk_i);
      check(ctl_halt_o, 1'b1);
      sw1_closed_n_i[0] <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(ctl_halt_o, 1'b0);
   endtask
   task automatic t_defaults();
      check({unit_num_o, selftest_loop_o, auto_boot_o}, 5'h00);
      check({dma_addr_hi_oe_n_o, dma_addr_o}, {4'hF, 22'h03FFFF});
      wb(1'b0, OFS_SWRAW, 32'h0, rd);
      check(rd, 32'h0);
      $display("test defaults done");
   endtask
   // soft halt blocks decode; status ignores a write and an unmapped offset reads zero
   task automatic t_regs();
      wb(1'b1, OFS_CONFIG, 32'h1, rd);
      repeat (6) @(posedge clk_i);
      check(ctl_halt_o, 1'b1);
      probe_chk({4'h0, BASE_ADDR_0}, 1'b0, 1'b0);
      wb(1'b0, OFS_CONFIG, 32'h0, rd);
      check(rd, 32'h1);
      wb(1'b1, OFS_CONFIG, 32'h0, rd);
      repeat (8) @(posedge clk_i);
      wb(1'b1, OFS_STATUS, 32'h0, rd);
      wb(1'b0, OFS_STATUS, 32'h0, rd);
      check(rd[0], 1'b1);
      wb(1'b0, 4'h2, 32'h0, rd);
      check(rd, 32'h0);
      $display("test registers done");
   endtask
   task automatic t_table();
      for (int c = 0; c < 8; c++) begin
         apply({c[2:0], 1'b0}, {c[0], 2'b00, c[2:0], c[1], c[2]});
         check({unit_num_o, selftest_loop_o, auto_boot_o}, {c[2:0], c[2], c[1]});
         probe_chk({4'h0, BASES[c]}, 1'b1, 1'b0);
         probe_chk({4'h0, BASES[c] + REG_STRIDE}, 1'b0, 1'b1);
         probe_chk({4'h0, BASES[c] + 18'h00004}, 1'b0, 1'b0);
         probe_chk({4'h0, BASES[c] - REG_STRIDE}, 1'b0, 1'b0);
         wb(1'b0, OFS_DECODE, 32'h0, rd);
         check(rd, {14'h0, BASES[c]});
         wb(1'b0, OFS_STATUS, 32'h0, rd);
         check(rd, {20'h0, 3'b000, c[2:0], c[1], c[2], c[2:0], 1'b1});
         wb(1'b0, OFS_SWRAW, 32'h0, rd);
         check(rd, {20'h0, c[0], 2'b00, c[2:0], c[1], c[2], c[2:0], 1'b0});
      end
      $display("test table done");
   endtask
   task automatic t_wide();
      apply(4'h0, 8'h20);
      check({dma_addr_hi_oe_n_o, dma_addr_o}, {4'h0, 22'h3FFFFF});
      probe_chk({4'h0, BASE_ADDR_0}, 1'b0, 1'b0);
      probe_chk({4'hF, BASE_ADDR_0}, 1'b1, 1'b0);
      $display("test wide done");
   endtask
   // a second burst end inside the gap must not restart it
   task automatic gap_run(input int lim);
      int n = 0;
      @(posedge clk_i);
      burst_done_i <= 1'b1;
      @(posedge clk_i);
      burst_done_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check(burst_ok_o, 1'b0);
      repeat (100) @(posedge clk_i);
      burst_done_i <= 1'b1;
      @(posedge clk_i);
      burst_done_i <= 1'b0;
      while (burst_ok_o !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      check(n + 102 >= lim - 1 && n + 102 <= lim + 1, 1'b1);
      $display("test gap done");
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      t_defaults();
      t_regs();
      t_table();
      t_wide();
      gap_run(GAP_SHORT_CYC);
      apply(4'h0, 8'h40);
      gap_run(GAP_LONG_CYC);
      give_verdict();
   end
   // whole run is about 3500 cycles; nearly six times that means a hang
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      give_verdict();
   end
endmodule // scs_top_tb
